// ==== async_serial_pkg.sv ====
// Summary of operation
// R01 - asynchronous mode while clocked-mode bit clear
// R02 - frame: start, 8 or 9 data, stop
// R03 - data bits travel least significant first
// R04 - transmitter, receiver independent, shared format, rate
// R05 - baud clock is 16x or 64x bit rate
// R06 - no hardware parity; ninth bit for software
// R07 - runs in low power; sleep halts it
// R08 - shifter reloads only after stop bit sent
// R09 - buffer-to-shifter move takes one cycle, sets flag
// R10 - tx flag cleared only by buffer write
// R11 - tx flag valid from second cycle after write
// R12 - shift-empty status bit, no interrupt
// R13 - transmit shifter has no software address
// R14 - enabling transmitter sets tx flag at once
// R15 - ninth bit enable sends ninth value bit
// R16 - buffer write with port enabled starts frame
// R17 - receive sampled at 16x, shifted per bit
// R18 - receive needs continuous enable, port enable, async
// R19 - complete frame sets rx flag, irq if enabled
// R20 - status shows ninth bit and errors of frame
// R21 - clearing continuous enable clears receive errors
// R22 - address detect passes only address frames
// R23 - receiver idle flag shows receive in progress
// R24 - address frame has ninth bit one
// R25 - framing error on low stop; overrun when full
// R26 - reading receive buffer clears rx flag
package async_serial_pkg;

   // ==========================================
   // register offsets (byte addresses)
   localparam logic [7:0] OFF_IRQ_FLAGS = 8'h00;
   localparam logic [7:0] OFF_IRQ_ENABLES = 8'h04;
   localparam logic [7:0] OFF_IRQ_PRIORITY = 8'h08;
   localparam logic [7:0] OFF_RX_STATUS = 8'h0c;
   localparam logic [7:0] OFF_TX_BUFFER = 8'h10;
   localparam logic [7:0] OFF_TX_STATUS = 8'h14;
   localparam logic [7:0] OFF_BAUD_CTRL = 8'h18;
   localparam logic [7:0] OFF_DIV_HIGH = 8'h1c;
   localparam logic [7:0] OFF_DIV_LOW = 8'h20;
   localparam logic [7:0] OFF_RX_BUFFER = 8'h24;

   // ==========================================
   // field positions
   localparam int RX_IRQ_BIT = 5;
   localparam int TX_IRQ_BIT = 4;
   localparam int PORT_EN_BIT = 7;
   localparam int RX_NINE_BIT = 6;
   localparam int CONT_RX_BIT = 4;
   localparam int ADDR_DET_BIT = 3;
   localparam int FRAME_ERR_BIT = 2;
   localparam int OVERRUN_BIT = 1;
   localparam int RX_NINTH_VAL_BIT = 0;
   localparam int TX_NINE_BIT = 6;
   localparam int TX_EN_BIT = 5;
   localparam int CLOCKED_MODE_BIT = 4;
   localparam int HIGH_SPEED_BIT = 2;
   localparam int SHIFT_EMPTY_BIT = 1;
   localparam int TX_NINTH_VAL_BIT = 0;
   localparam int RX_IDLE_BIT = 6;
   localparam int WIDE_DIV_BIT = 3;

   // ==========================================
   // reset values and writable masks
   localparam logic [7:0] RESET_BYTE = 8'h00;
   localparam logic [7:0] TX_STATUS_RESET = 8'h02;
   localparam logic [7:0] RX_STATUS_WMASK = 8'hf8;
   localparam logic [7:0] TX_STATUS_WMASK = 8'hfd;
   localparam logic [7:0] BAUD_CTRL_WMASK = 8'h08;
   localparam logic [7:0] IRQ_WMASK = 8'h30;

   // ==========================================
   // timing counts in oversample ticks, prescale steps and frame bits
   localparam logic [3:0] BIT_LAST_TICK = 4'hf;
   localparam logic [3:0] MID_TICK = 4'h7;
   localparam logic [1:0] X64_PRESCALE_LAST = 2'h3;
   localparam logic [3:0] FRAME_BITS_8 = 4'ha;
   localparam logic [3:0] FRAME_BITS_9 = 4'hb;
   localparam logic [3:0] RX_LAST_BIT_8 = 4'h7;
   localparam logic [3:0] RX_LAST_BIT_9 = 4'h8;

   typedef enum logic {TX_IDLE, TX_SEND} tx_state_t;
   typedef enum logic [1:0] {RX_IDLE, RX_START, RX_DATA, RX_STOP} rx_state_t;

endpackage

// ==== rx_pin_sync.sv ====
`timescale 1ns/10ps
`default_nettype none
module rx_pin_sync
   import async_serial_pkg::*;
(
   // clock and reset
   input wire logic core_clk,
   input wire logic nrst,
   // pin and filtered level
   input wire logic pin,
   output logic level
);

   typedef struct packed {
      logic s1;
      logic s2;
      logic s3;
      logic lvl;
   } sync_t;

   sync_t s;
   sync_t next_s;

   // the line idles high, so reset to the idle level
   always_comb begin
      next_s = s;
      next_s.s1 = pin;
      next_s.s2 = s.s1;
      next_s.s3 = s.s2;
      if (s.s2 == s.s3) begin
         next_s.lvl = s.s3;
      end
   end

   always_ff @(posedge core_clk) begin
      if (!nrst) begin
         s <= '1;
      end else begin
         s <= next_s;
      end
   end

   assign level = s.lvl;

endmodule
`default_nettype wire

// ==== baud_tick_gen.sv ====
`timescale 1ns/10ps
`default_nettype none
module baud_tick_gen
   import async_serial_pkg::*;
(
   // clock and reset
   input wire logic core_clk,
   input wire logic nrst,
   // configuration
   input wire logic run,
   input wire logic x64,
   input wire logic [15:0] divisor,
   // one tick per sixteenth of a bit
   output logic tick
);

   typedef struct packed {
      logic [15:0] cnt;
      logic [1:0] pre;
   } brg_t;

   brg_t s;
   brg_t next_s;

   always_comb begin
      next_s = s;
      tick = 1'b0;
      if (!run) begin
         next_s = '0;
      end else if (s.cnt == 16'h0000) begin
         next_s.cnt = divisor;
         // x64 base clock is divided by four to give the x16 sample rate
         if (!x64 || s.pre == X64_PRESCALE_LAST) begin // R05
            tick = 1'b1;
            next_s.pre = 2'h0;
         end else begin
            next_s.pre = s.pre + 2'h1;
         end
      end else begin
         next_s.cnt = s.cnt - 16'h0001;
      end
   end

   always_ff @(posedge core_clk) begin
      if (!nrst) begin
         s <= '0;
      end else begin
         s <= next_s;
      end
   end

endmodule
`default_nettype wire

// ==== async_serial_transceiver.sv ====
`timescale 1ns/10ps
`default_nettype none
module async_serial_transceiver
   import async_serial_pkg::*;
(
   // clock and reset
   input wire logic core_clk,
   input wire logic nrst,
   // apb slave
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   // serial pins
   input wire logic rx_pin,
   output logic tx_pin,
   output logic tx_pin_oe,
   // power state
   input wire logic sleep_mode,
   // interrupt requests
   output logic rx_irq_req,
   output logic tx_irq_req
);

   // ==========================================
   // state

   typedef struct packed {
      logic [7:0] rd_data;
      logic [7:0] rx_ctl;
      logic [7:0] tx_ctl;
      logic [7:0] baud_ctl;
      logic [7:0] irq_en;
      logic [7:0] irq_prio;
      logic [7:0] div_hi;
      logic [7:0] div_lo;
      logic [7:0] tx_buf;
      logic tx_full;
      logic tx_flag;
      tx_state_t tx_st;
      logic [10:0] tx_shift;
      logic [3:0] tx_left;
      logic [3:0] tx_tick;
      logic tx_line;
      logic tx_oe;
      rx_state_t rx_st;
      logic [8:0] rx_shift;
      logic [3:0] rx_cnt;
      logic [3:0] rx_tick;
      logic [7:0] rx_buf;
      logic rx_full;
      logic rx_ninth;
      logic framing_error_flag;
      logic overrun_error_flag;
   } state_t;

   state_t s;
   state_t next_s;

   function automatic logic is_mapped(input logic [7:0] a);
      is_mapped = (a == OFF_IRQ_FLAGS) || (a == OFF_IRQ_ENABLES) ||
                  (a == OFF_IRQ_PRIORITY) || (a == OFF_RX_STATUS) ||
                  (a == OFF_TX_BUFFER) || (a == OFF_TX_STATUS) ||
                  (a == OFF_BAUD_CTRL) || (a == OFF_DIV_HIGH) ||
                  (a == OFF_DIV_LOW) || (a == OFF_RX_BUFFER);
   endfunction

   // ==========================================
   // shared pieces

   logic rx_level;
   logic tick;
   logic port_on;
   logic tx_on;
   logic rx_on;
   logic wr_en;
   logic rd_en;
   logic wr_txbuf;
   logic rd_rxbuf;
   logic tx_load;
   logic transmitter_enable_rise;
   logic rx_done;
   logic rx_keep;
   logic rx_nine_val;
   logic [7:0] rx_data;
   logic [3:0] rx_last;
   logic [7:0] irq_flags;
   logic [7:0] rx_stat;
   logic [7:0] tx_stat;
   logic [7:0] baud_stat;
   logic [7:0] read_mux;

   rx_pin_sync u_rx_sync (
      .core_clk(core_clk),
      .nrst(nrst),
      .pin(rx_pin),
      .level(rx_level)
   );

   // sleep stops the rate generator, so the transmitter freezes; the receiver is forced back to idle
   // both rate bits set still gives x16; there is no x4 mode
   baud_tick_gen u_baud (
      .core_clk(core_clk),
      .nrst(nrst),
      .run(port_on && !sleep_mode), // R07
      .x64(!s.tx_ctl[HIGH_SPEED_BIT] && !s.baud_ctl[WIDE_DIV_BIT]), // R05
      .divisor(s.baud_ctl[WIDE_DIV_BIT] ? {s.div_hi, s.div_lo} : {8'h00, s.div_lo}),
      .tick(tick)
   );

   // one tick stream feeds both directions
   assign port_on = s.rx_ctl[PORT_EN_BIT] && !s.tx_ctl[CLOCKED_MODE_BIT]; // R01 R04
   assign tx_on = port_on && s.tx_ctl[TX_EN_BIT]; // R16
   assign rx_on = port_on && s.rx_ctl[CONT_RX_BIT] && !s.overrun_error_flag && !sleep_mode; // R18 R07

   assign wr_en = psel && penable && pwrite;
   assign rd_en = psel && penable && !pwrite;
   assign wr_txbuf = wr_en && (paddr == OFF_TX_BUFFER);
   assign rd_rxbuf = rd_en && (paddr == OFF_RX_BUFFER);
   assign transmitter_enable_rise = wr_en && (paddr == OFF_TX_STATUS) && pwdata[TX_EN_BIT] && !s.tx_ctl[TX_EN_BIT];

   // shifter reloads only once the stop bit has fully left
   // and never while asleep, or a start bit would freeze on the line
   assign tx_load = s.tx_full && (s.tx_st == TX_IDLE) && tx_on && !sleep_mode; // R08 R07

   assign rx_last = s.rx_ctl[RX_NINE_BIT] ? RX_LAST_BIT_9 : RX_LAST_BIT_8;
   assign rx_nine_val = s.rx_ctl[RX_NINE_BIT] && s.rx_shift[8];
   assign rx_data = s.rx_ctl[RX_NINE_BIT] ? s.rx_shift[7:0] : s.rx_shift[8:1];

   // ==========================================
   // readback

   always_comb begin
      // unused flag bits read as zero
      irq_flags = RESET_BYTE;
      irq_flags[RX_IRQ_BIT] = s.rx_full;
      irq_flags[TX_IRQ_BIT] = s.tx_flag;
      rx_stat = s.rx_ctl;
      rx_stat[FRAME_ERR_BIT] = s.framing_error_flag; // R20
      rx_stat[OVERRUN_BIT] = s.overrun_error_flag;
      rx_stat[RX_NINTH_VAL_BIT] = s.rx_ninth;
      tx_stat = s.tx_ctl;
      tx_stat[SHIFT_EMPTY_BIT] = (s.tx_st == TX_IDLE); // R12
      baud_stat = s.baud_ctl;
      baud_stat[RX_IDLE_BIT] = (s.rx_st == RX_IDLE); // R23
      unique case (paddr)
         OFF_IRQ_FLAGS: read_mux = irq_flags;
         OFF_IRQ_ENABLES: read_mux = s.irq_en;
         OFF_IRQ_PRIORITY: read_mux = s.irq_prio;
         OFF_RX_STATUS: read_mux = rx_stat;
         OFF_TX_BUFFER: read_mux = s.tx_buf;
         OFF_TX_STATUS: read_mux = tx_stat;
         OFF_BAUD_CTRL: read_mux = baud_stat;
         OFF_DIV_HIGH: read_mux = s.div_hi;
         OFF_DIV_LOW: read_mux = s.div_lo;
         OFF_RX_BUFFER: read_mux = s.rx_buf;
         default: read_mux = RESET_BYTE;
      endcase
   end

   // ==========================================
   // next state

   always_comb begin
      next_s = s;
      rx_done = 1'b0;
      rx_keep = 1'b0;

      // read data is captured in the setup phase, so no wait state is needed
      if (psel && !penable) begin
         next_s.rd_data = read_mux;
      end

      // the shifter itself has no address at all
      if (wr_en) begin // R13
         case (paddr)
            OFF_IRQ_ENABLES: next_s.irq_en = pwdata[7:0] & IRQ_WMASK;
            OFF_IRQ_PRIORITY: next_s.irq_prio = pwdata[7:0] & IRQ_WMASK;
            OFF_RX_STATUS: next_s.rx_ctl = pwdata[7:0] & RX_STATUS_WMASK;
            OFF_TX_BUFFER: next_s.tx_buf = pwdata[7:0];
            OFF_TX_STATUS: next_s.tx_ctl = pwdata[7:0] & TX_STATUS_WMASK;
            OFF_BAUD_CTRL: next_s.baud_ctl = pwdata[7:0] & BAUD_CTRL_WMASK;
            OFF_DIV_HIGH: next_s.div_hi = pwdata[7:0];
            OFF_DIV_LOW: next_s.div_lo = pwdata[7:0];
            default: ;
         endcase
      end

      // ------------------------------------------
      // transmit holding buffer and flag
      next_s.tx_full = (s.tx_full && !tx_load) || wr_txbuf; // R16
      if (wr_txbuf) begin
         // a write that meets a load leaves new data waiting, so the flag stays low
         next_s.tx_flag = 1'b0; // R10
      end else if (tx_load) begin
         next_s.tx_flag = 1'b1; // R09 R11
      end else if (transmitter_enable_rise && !s.tx_full) begin
         next_s.tx_flag = 1'b1; // R14
      end

      // ------------------------------------------
      // transmit shifter
      if (tx_load) begin
         // stop, ninth-or-stop, data, start; shifted out from bit 0
         next_s.tx_shift = {1'b1, s.tx_ctl[TX_NINE_BIT] ? s.tx_ctl[TX_NINTH_VAL_BIT] : 1'b1,
                            s.tx_buf, 1'b0}; // R02 R15 R06
         next_s.tx_left = s.tx_ctl[TX_NINE_BIT] ? FRAME_BITS_9 : FRAME_BITS_8; // R15
         next_s.tx_tick = 4'h0;
         next_s.tx_st = TX_SEND;
      end else if (s.tx_st == TX_SEND && tick) begin
         if (s.tx_tick == BIT_LAST_TICK) begin
            next_s.tx_tick = 4'h0;
            next_s.tx_shift = {1'b1, s.tx_shift[10:1]}; // R03
            next_s.tx_left = s.tx_left - 4'h1;
            if (s.tx_left == 4'h1) begin
               next_s.tx_st = TX_IDLE; // R08
            end
         end else begin
            next_s.tx_tick = s.tx_tick + 4'h1;
         end
      end
      // dropping the enable abandons a frame, so the line cannot park low
      if (!tx_on) begin
         next_s.tx_st = TX_IDLE;
         next_s.tx_tick = 4'h0;
      end
      next_s.tx_line = (next_s.tx_st == TX_SEND) ? next_s.tx_shift[0] : 1'b1;
      // pin stays driven between frames
      next_s.tx_oe = port_on;

      // ------------------------------------------
      // receiver: one decision per sixteen oversample ticks
      unique case (s.rx_st)
         RX_IDLE: begin
            if (rx_on && !rx_level) begin
               next_s.rx_st = RX_START;
               next_s.rx_tick = 4'h0;
            end
         end
         RX_START: begin
            if (tick) begin // R17
               if (s.rx_tick == MID_TICK) begin
                  // a glitch shorter than half a bit is not a start
                  next_s.rx_st = rx_level ? RX_IDLE : RX_DATA;
                  next_s.rx_tick = 4'h0;
                  next_s.rx_cnt = 4'h0;
               end else begin
                  next_s.rx_tick = s.rx_tick + 4'h1;
               end
            end
         end
         RX_DATA: begin
            if (tick) begin
               if (s.rx_tick == BIT_LAST_TICK) begin
                  next_s.rx_tick = 4'h0;
                  next_s.rx_shift = {rx_level, s.rx_shift[8:1]}; // R03
                  next_s.rx_cnt = s.rx_cnt + 4'h1;
                  if (s.rx_cnt == rx_last) begin // R02
                     next_s.rx_st = RX_STOP;
                  end
               end else begin
                  next_s.rx_tick = s.rx_tick + 4'h1;
               end
            end
         end
         RX_STOP: begin
            if (tick) begin
               if (s.rx_tick == BIT_LAST_TICK) begin
                  rx_done = 1'b1;
                  next_s.rx_st = RX_IDLE;
               end else begin
                  next_s.rx_tick = s.rx_tick + 4'h1;
               end
            end
         end
      endcase
      if (!rx_on) begin
         next_s.rx_st = RX_IDLE; // R18
         next_s.rx_tick = 4'h0;
         next_s.rx_cnt = 4'h0;
      end

      // non-address frames are dropped silently in address-detect mode with nine-bit receive set
      rx_keep = rx_done && !(s.rx_ctl[ADDR_DET_BIT] && s.rx_ctl[RX_NINE_BIT] && !rx_nine_val); // R22 R24

      // ------------------------------------------
      // receive buffer; a completion in the read cycle wins over the clear
      if (rd_rxbuf) begin
         next_s.rx_full = 1'b0; // R26
      end
      if (rx_keep) begin
         if (s.rx_full && !rd_rxbuf) begin
            // single-entry buffer: the new frame is lost and reception halts
            next_s.overrun_error_flag = 1'b1; // R25
         end else begin
            next_s.rx_full = 1'b1; // R19
            next_s.rx_buf = rx_data;
            next_s.rx_ninth = rx_nine_val; // R20
            // each stored frame carries its own framing status
            next_s.framing_error_flag = !rx_level; // R25
         end
      end

      if (!next_s.rx_ctl[CONT_RX_BIT]) begin
         next_s.overrun_error_flag = 1'b0; // R21
         next_s.framing_error_flag = 1'b0; // R21
      end
   end

   // ==========================================
   // registers

   always_ff @(posedge core_clk) begin
      if (!nrst) begin
         s <= '0;
         s.tx_ctl <= TX_STATUS_RESET & TX_STATUS_WMASK;
         s.tx_st <= TX_IDLE;
         s.rx_st <= RX_IDLE;
         s.tx_line <= 1'b1;
      end else begin
         s <= next_s;
      end
   end

   // ==========================================
   // outputs

   assign prdata = {24'h000000, s.rd_data};
   assign pready = psel && penable;
   assign pslverr = psel && penable && !is_mapped(paddr);
   assign tx_pin = s.tx_line;
   assign tx_pin_oe = s.tx_oe;
   assign rx_irq_req = s.rx_full && s.irq_en[RX_IRQ_BIT]; // R19
   assign tx_irq_req = s.tx_flag && s.irq_en[TX_IRQ_BIT];

endmodule
`default_nettype wire

// ==== async_serial_transceiver_checker.sv ====
`timescale 1ns/10ps
`default_nettype none
module async_serial_transceiver_checker
   import async_serial_pkg::*;
(
   // clock and reset
   input wire logic core_clk,
   input wire logic nrst,
   // apb slave
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic [31:0] prdata,
   input wire logic pready,
   input wire logic pslverr,
   // serial pins
   input wire logic rx_pin,
   input wire logic tx_pin,
   input wire logic tx_pin_oe,
   // power and interrupts
   input wire logic sleep_mode,
   input wire logic rx_irq_req,
   input wire logic tx_irq_req
);
   // ==========================================
   // shadow of written control bits, length of the current low run on the line
   default clocking cb @(posedge core_clk); endclocking
   default disable iff (!nrst);
   logic wr_acc;
   logic [7:0] rx_ctl;
   logic [7:0] tx_ctl;
   logic [7:0] low_run;
   assign wr_acc = psel && penable && pwrite;
   always_ff @(posedge core_clk) begin
      if (!nrst) begin
         rx_ctl <= 8'h00;
         tx_ctl <= 8'h00;
         low_run <= 8'h00;
      end else begin
         if (wr_acc && paddr == OFF_RX_STATUS) rx_ctl <= pwdata[7:0];
         if (wr_acc && paddr == OFF_TX_STATUS) tx_ctl <= pwdata[7:0];
         low_run <= tx_pin ? 8'h00 : ((low_run == 8'hff) ? low_run : low_run + 8'h01);
      end
   end
   sequence s_setup;
      psel && !penable;
   endsequence
   sequence s_access;
      psel && penable;
   endsequence
   // ==========================================
   // properties
   chk_ready_no_wait: assert property (s_setup ##1 s_access |-> pready)
      else $error("access phase without ready");
   chk_unmapped_err: assert property (s_access and (!pwrite && (paddr > OFF_RX_BUFFER || paddr[1:0] != 2'h0))
      |-> pslverr && prdata == 32'h0)
      else $error("unmapped read not refused");
   chk_err_in_access: assert property (pslverr |-> psel && penable)
      else $error("error outside access phase");
   chk_tx_flag_hold: assert property ($fell(tx_irq_req) |-> $past(wr_acc && (paddr == OFF_TX_BUFFER
      || paddr == OFF_IRQ_ENABLES)))
      else $error("tx flag dropped without buffer write");
   chk_rx_flag_clear: assert property ($fell(rx_irq_req) |-> $past(psel && penable && ((!pwrite && paddr ==
      OFF_RX_BUFFER) || (pwrite && (paddr == OFF_IRQ_ENABLES || paddr == OFF_RX_STATUS)))))
      else $error("rx flag dropped without read");
   chk_rx_gate: assert property ($rose(rx_irq_req) |-> $past(wr_acc && paddr == OFF_IRQ_ENABLES)
      || (rx_ctl[PORT_EN_BIT] && rx_ctl[CONT_RX_BIT] && !tx_ctl[CLOCKED_MODE_BIT]))
      else $error("frame accepted while receiver off");
   chk_oe_async: assert property (tx_pin_oe == $past(rx_ctl[PORT_EN_BIT] && !tx_ctl[CLOCKED_MODE_BIT]))
      else $error("pin enable does not follow port mode");
   chk_line_parked: assert property (!tx_pin_oe |-> tx_pin)
      else $error("line not idle high while off");
   chk_bit_length: assert property ($rose(tx_pin) && tx_pin_oe |-> low_run >= 8'h10)
      else $error("low run shorter than one bit");
endmodule
bind async_serial_transceiver async_serial_transceiver_checker u_checker (
   .core_clk(core_clk), .nrst(nrst), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
   .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .rx_pin(rx_pin), .tx_pin(tx_pin),
   .tx_pin_oe(tx_pin_oe), .sleep_mode(sleep_mode), .rx_irq_req(rx_irq_req), .tx_irq_req(tx_irq_req)
);
`default_nettype wire

// ==== async_serial_remote.sv ====
`timescale 1ns/10ps
`default_nettype none
module async_serial_remote (
   // clock
   input wire logic core_clk,
   // device transmit line in, device receive line out
   input wire logic line_in,
   output logic line_out
);
   // ==========================================
   // remote node: sender and mid-bit sampler
   int bit_cycles = 16;
   int data_bits = 8;
   int got_count = 0;
   logic [8:0] got_data = 9'h000;
   initial line_out = 1'b1;
   // a low stop level is sent only when a scenario asks for a framing fault
   task automatic send_frame(input logic [8:0] data, input int nbits, input logic stop_level);
      int i;
      line_out <= 1'b0;
      repeat (bit_cycles) @(posedge core_clk);
      for (i = 0; i < nbits; i++) begin
         line_out <= data[i];
         repeat (bit_cycles) @(posedge core_clk);
      end
      line_out <= stop_level;
      repeat (bit_cycles) @(posedge core_clk);
      line_out <= 1'b1;
      @(posedge core_clk);
   endtask
   always begin : listen
      int i;
      logic [8:0] v;
      @(negedge line_in);
      repeat (bit_cycles / 2) @(posedge core_clk);
      v = 9'h000;
      for (i = 0; i < data_bits; i++) begin
         repeat (bit_cycles) @(posedge core_clk);
         v[i] = line_in;
      end
      repeat (bit_cycles) @(posedge core_clk);
      got_data = v;
      got_count++;
   end
endmodule
`default_nettype wire

// ==== test_async_serial_transceiver.sv ====
`timescale 1ns/10ps
`default_nettype none
module test_async_serial_transceiver import async_serial_pkg::*;;
   logic core_clk = 1'b0;
   logic nrst = 1'b0;
   logic psel = 1'b0;
   logic penable = 1'b0;
   logic pwrite = 1'b0;
   logic [7:0] paddr = 8'h00;
   logic [31:0] pwdata = 32'h0;
   logic sleep_mode = 1'b0;
   logic [31:0] prdata;
   logic pready, pslverr, rx_pin, tx_pin, tx_pin_oe, rx_irq_req, tx_irq_req;
   logic [7:0] rd;
   logic err;
   int fails = 0;
   int total_checks = 0;
   always #5 core_clk = ~core_clk;
   async_serial_transceiver u_async_serial_transceiver (
      .core_clk(core_clk), .nrst(nrst), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
      .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .rx_pin(rx_pin), .tx_pin(tx_pin),
      .tx_pin_oe(tx_pin_oe), .sleep_mode(sleep_mode), .rx_irq_req(rx_irq_req), .tx_irq_req(tx_irq_req)
   );
   async_serial_remote u_async_serial_remote (.core_clk(core_clk), .line_in(tx_pin), .line_out(rx_pin));
   // ==========================================
   // report and compare
   task automatic wrap_up();
      $display("checks %0d mismatches %0d", total_checks, fails);
      if (fails == 0 && total_checks > 0) $display("RESULT: PASS");
      else $display("RESULT: FAIL");
      $finish;
   endtask
   task automatic check9(input string what, input logic [8:0] exp, input logic [8:0] got);
      total_checks++;
      if (got !== exp) begin
         fails++;
         $display("mismatch %s expected %h seen %h", what, exp, got);
      end
   endtask
   task automatic check1(input string what, input logic exp, input logic got);
      total_checks++;
      if (got !== exp) begin
         fails++;
         $display("mismatch %s expected %b seen %b", what, exp, got);
      end
   endtask
   // ==========================================
   // bus and line helpers, all entered just after a rising edge
   task automatic apb(input logic w, input logic [7:0] a, input logic [7:0] d);
      int n;
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= w;
      paddr <= a;
      pwdata <= {24'h000000, d};
      @(posedge core_clk);
      penable <= 1'b1;
      n = 0;
      do begin
         @(posedge core_clk);
         n++;
      end while (pready !== 1'b1 && n < 16);
      if (pready !== 1'b1) begin
         fails++;
         wrap_up();
      end
      rd = prdata[7:0];
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge core_clk);
   endtask
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      apb(1'b1, a, d);
   endtask
   task automatic rd_chk(input string what, input logic [7:0] a, input logic [7:0] exp);
      apb(1'b0, a, 8'h00);
      check9(what, {1'b0, exp}, {1'b0, rd});
   endtask
   task automatic wait_frames(input int target);
      int n;
      for (n = 0; n < 1000 && u_async_serial_remote.got_count < target; n++) @(posedge core_clk);
      if (u_async_serial_remote.got_count < target) begin
         fails++;
         wrap_up();
      end
   endtask
   task automatic rx_case(input logic [8:0] d, input int nbits, input logic stop, input logic exp_irq,
                          input logic [7:0] exp_stat, input logic [7:0] exp_buf);
      int n;
      u_async_serial_remote.send_frame(d, nbits, stop);
      for (n = 0; n < 40 && rx_irq_req !== 1'b1; n++) @(posedge core_clk);
      check1("rx_irq_req", exp_irq, rx_irq_req);
      rd_chk("rx status", OFF_RX_STATUS, exp_stat);
      if (exp_irq) begin
         rd_chk("rx data", OFF_RX_BUFFER, exp_buf);
         rd_chk("rx flag after read", OFF_IRQ_FLAGS, 8'h10);
      end
   endtask
   // ==========================================
   // scenarios
   initial begin : main
      int i;
      repeat (10) @(posedge core_clk);
      nrst <= 1'b1;
      @(posedge core_clk);
      for (i = 0; i < 10; i++) rd_chk("reset value", 8'(i * 4), (i == 5) ? 8'h02 : ((i == 6) ? 8'h40 : 8'h00));
      apb(1'b0, 8'h28, 8'h00);
      check1("unmapped error", 1'b1, err);
      check9("unmapped data", 9'h000, {1'b0, rd});
      $display("test reset and map done");
      wr(OFF_DIV_LOW, 8'h00);
      wr(OFF_RX_STATUS, 8'h80);
      wr(OFF_TX_STATUS, 8'h24);
      wr(OFF_IRQ_FLAGS, 8'h00);
      rd_chk("tx flag on enable", OFF_IRQ_FLAGS, 8'h10);
      wr(OFF_IRQ_ENABLES, 8'h30);
      check1("tx irq", 1'b1, tx_irq_req);
      check1("tx pin enable", 1'b1, tx_pin_oe);
      wr(OFF_TX_BUFFER, 8'ha5);
      wr(OFF_TX_BUFFER, 8'h3c);
      rd_chk("tx flag while full", OFF_IRQ_FLAGS, 8'h00);
      rd_chk("shifter busy", OFF_TX_STATUS, 8'h24);
      wait_frames(1);
      check9("first frame", 9'h0a5, u_async_serial_remote.got_data);
      wait_frames(2);
      check9("second frame", 9'h03c, u_async_serial_remote.got_data);
      repeat (16) @(posedge core_clk);
      rd_chk("shifter empty", OFF_TX_STATUS, 8'h26);
      rd_chk("tx flag empty", OFF_IRQ_FLAGS, 8'h10);
      u_async_serial_remote.data_bits = 9;
      wr(OFF_TX_STATUS, 8'h65);
      wr(OFF_TX_BUFFER, 8'h5a);
      wait_frames(3);
      check9("ninth bit frame", 9'h15a, u_async_serial_remote.got_data);
      $display("test transmit done");
      rx_case(9'h0f0, 8, 1'b1, 1'b0, 8'h80, 8'h00);
      wr(OFF_RX_STATUS, 8'h90);
      fork
         rx_case(9'h096, 8, 1'b1, 1'b1, 8'h90, 8'h96);
         begin
            repeat (40) @(posedge core_clk);
            rd_chk("receiver busy", OFF_BAUD_CTRL, 8'h00);
         end
      join
      rx_case(9'h011, 8, 1'b0, 1'b1, 8'h94, 8'h11);
      u_async_serial_remote.send_frame(9'h001, 8, 1'b1);
      rx_case(9'h002, 8, 1'b1, 1'b1, 8'h92, 8'h01);
      wr(OFF_RX_STATUS, 8'h80);
      rd_chk("errors cleared", OFF_RX_STATUS, 8'h80);
      $display("test receive done");
      wr(OFF_RX_STATUS, 8'hd8);
      rx_case(9'h0aa, 9, 1'b1, 1'b0, 8'hd8, 8'h00);
      rx_case(9'h1bb, 9, 1'b1, 1'b1, 8'hd9, 8'hbb);
      wr(OFF_RX_STATUS, 8'hd0);
      rx_case(9'h0cc, 9, 1'b1, 1'b1, 8'hd0, 8'hcc);
      $display("test address detect done");
      u_async_serial_remote.data_bits = 8;
      u_async_serial_remote.bit_cycles = 64;
      wr(OFF_TX_STATUS, 8'h20);
      sleep_mode <= 1'b1;
      wr(OFF_TX_BUFFER, 8'h81);
      repeat (100) @(posedge core_clk);
      check1("tx line asleep", 1'b1, tx_pin);
      sleep_mode <= 1'b0;
      wait_frames(4);
      check9("x64 frame", 9'h081, u_async_serial_remote.got_data);
      $display("test sleep and x64 done");
      wrap_up();
   end
endmodule
`default_nettype wire
